// >>> fifo_host_model.sv
// Behavioural host strobing the FIFO pins
`timescale 1ns/1ns
`default_nettype none
module fifo_host_model (
    // Clock
    input wire logic ref_clk,
    // FIFO pins
    input wire logic [7:0] busLevel,
    input wire logic txSpaceN,
    input wire logic rxAvailN,
    output logic rdStrobeN,
    output logic wrStrobe,
    output logic [7:0] hostData,
    output logic hostOe
);
    initial begin
        rdStrobeN = 1'h1;
        wrStrobe = 1'h0;
        hostData = 8'hFF;
        hostOe = 1'h0;
    end
    // Ignoring the flag is only for refusal tests
    task automatic readByte(input bit ignoreFlag, output logic [7:0] d);
        for (int n = 0; n < 40 && !ignoreFlag && rxAvailN !== 1'h0; n++) @(posedge ref_clk);
        rdStrobeN <= 1'h0;
        repeat (5) @(posedge ref_clk);
        d = busLevel;
        rdStrobeN <= 1'h1;
        repeat (6) @(posedge ref_clk);
    endtask
    task automatic writeByte(input bit ignoreFlag, input logic [7:0] d);
        for (int n = 0; n < 40 && !ignoreFlag && txSpaceN !== 1'h0; n++) @(posedge ref_clk);
        hostData <= d;
        hostOe <= 1'h1;
        wrStrobe <= 1'h1;
        repeat (4) @(posedge ref_clk);
        wrStrobe <= 1'h0;
        // Data held through the falling cycle
        @(posedge ref_clk);
        hostOe <= 1'h0;
        hostData <= ~d;
        repeat (6) @(posedge ref_clk);
    endtask
endmodule
`default_nettype wire

// >>> usb_fifo_parallel_port_tb.sv
// Self-checking bench for the FIFO port
`timescale 1ns/1ns
`default_nettype none
`include "usb_fifo_port_defs.vh"
`define CHK(a, e) begin numChecks++; if ((a) !== (e)) begin failCount++; \
    $display("Error at %0t got %h expected %h", $time, (a), (e)); end end
module usb_fifo_parallel_port_tb;
    localparam int RST_DLY = 20;
    typedef struct {logic [7:0] din; logic [31:0] popExp;} row_t;
    row_t rows[4] = '{'{8'h01, 32'h101}, '{8'h80, 32'h180}, '{8'hA5, 32'h1A5}, '{8'h5A, 32'h15A}};
    int failCount = 0;
    int numChecks = 0;
    logic ref_clk = 1'h0;
    logic resetN = 1'h0;
    logic [7:0] fifoDataOut, hostData, b, awaddr = 8'h00, araddr = 8'h00;
    logic fifoDataOe, rdStrobeN, wrStrobe, txSpaceN, rxAvailN, powerEnableN, hostOe, m;
    logic delayedRstOutN, delayedRstOutOe, oscOut, awready, wready, bvalid, arready, rvalid;
    logic sendNowWakeN = 1'h1;
    logic testMode = 1'h0;
    logic promSelectIn = 1'h1;
    logic promClockIn = 1'h1;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic [1:0] bresp, rresp, r;
    // Pull-ups hold the bus high when nobody drives it
    wire [7:0] busLevel = fifoDataOe ? fifoDataOut : (hostOe ? hostData : 8'hFF);
    always #2 ref_clk = ~ref_clk;
    usb_fifo_port #(.RST_DELAY_CYCLES(RST_DLY)) u_usb_fifo_port (
        .ref_clk(ref_clk), .reset_n(resetN), .fifoDataIn(busLevel), .fifoDataOut(fifoDataOut),
        .fifoDataOe(fifoDataOe), .rdStrobeN(rdStrobeN), .wrStrobe(wrStrobe), .txSpaceN(txSpaceN),
        .rxAvailN(rxAvailN), .sendNowWakeN(sendNowWakeN), .powerEnableN(powerEnableN),
        .delayedRstOutN(delayedRstOutN), .delayedRstOutOe(delayedRstOutOe), .oscOut(oscOut),
        .testMode(testMode), .promSelectIn(promSelectIn), .promClockIn(promClockIn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready)
    );
    fifo_host_model u_fifo_host_model (
        .ref_clk(ref_clk), .busLevel(busLevel), .txSpaceN(txSpaceN), .rxAvailN(rxAvailN),
        .rdStrobeN(rdStrobeN), .wrStrobe(wrStrobe), .hostData(hostData), .hostOe(hostOe)
    );
    task automatic giveVerdict();
        $display("checks %0d mismatches %0d", numChecks, failCount);
        if (failCount == 0 && numChecks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic axiWr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
        @(posedge ref_clk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        forever begin
            @(posedge ref_clk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
            if (bvalid) break;
        end
        bready <= 1'h0;
        `CHK(bresp, er)
    endtask
    task automatic axiRd(input logic [7:0] a);
        @(posedge ref_clk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        forever begin
            @(posedge ref_clk);
            if (arready) arvalid <= 1'h0;
            if (rvalid) break;
        end
        rready <= 1'h0;
        d = rdata;
        r = rresp;
    endtask
    task automatic rdChk(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] e);
        axiRd(a);
        `CHK(d & mask, e)
    endtask
    // Half period is 22 cycles, so 50 always spans an edge
    task automatic oscWatch(output logic moved);
        logic o;
        o = oscOut;
        moved = 1'h0;
        repeat (50) begin
            @(posedge ref_clk);
            if (oscOut !== o) moved = 1'h1;
        end
    endtask
    task automatic pulseWake();
        sendNowWakeN <= 1'h0;
        repeat (4) @(posedge ref_clk);
        sendNowWakeN <= 1'h1;
        repeat (6) @(posedge ref_clk);
    endtask
    initial begin
        #240000;
        failCount++;
        giveVerdict();
    end
    initial begin
        repeat (2) @(posedge ref_clk);
        `CHK({txSpaceN, rxAvailN, powerEnableN}, 3'h7)
        `CHK({delayedRstOutOe, delayedRstOutN}, 2'h2)
        repeat (2) @(posedge ref_clk);
        resetN <= 1'h1;
        repeat (3) @(posedge ref_clk);
        `CHK(delayedRstOutOe, 1'h0)
        repeat (RST_DLY + 4) @(posedge ref_clk);
        `CHK({delayedRstOutOe, delayedRstOutN}, 2'h3)
        rdChk(`REG_PRODUCT, 32'hFFFF, {16'h0, `PID_DEFAULT});
        rdChk(`REG_STATUS, 32'hC, 32'h0);
        foreach (rows[i]) begin
            axiWr(`REG_RX_PUSH, {24'h0, rows[i].din}, `RESP_OKAY);
            u_fifo_host_model.readByte(1'h0, b);
            `CHK(b, rows[i].din)
            u_fifo_host_model.writeByte(1'h0, rows[i].din);
            rdChk(`REG_TX_POP, 32'hFFFFFFFF, rows[i].popExp);
        end
        for (int i = 0; i < 129; i++) axiWr(`REG_RX_PUSH, 32'(i), `RESP_OKAY);
        rdChk(`REG_STATUS, 32'hFF000000, 32'h80000000);
        for (int i = 0; i < 128; i++) begin
            u_fifo_host_model.readByte(1'h0, b);
            `CHK(b, 8'(i))
        end
        `CHK(rxAvailN, 1'h1)
        u_fifo_host_model.readByte(1'h1, b);
        rdChk(`REG_STATUS, 32'hFF000000, 32'h0);
        for (int i = 0; i < 384; i++) u_fifo_host_model.writeByte(1'h0, 8'(i));
        `CHK(txSpaceN, 1'h1)
        rdChk(`REG_STATUS, 32'h1FF00, 32'h18000);
        rdChk(`REG_TX_POP, 32'h1FF, 32'h100);
        repeat (4) @(posedge ref_clk);
        `CHK(txSpaceN, 1'h0)
        axiWr(`REG_CTRL, 32'h1, `RESP_OKAY);
        repeat (2) @(posedge ref_clk);
        `CHK(powerEnableN, 1'h0)
        oscWatch(m);
        `CHK(m, 1'h1)
        pulseWake();
        rdChk(`REG_STATUS, 32'h3, 32'h1);
        axiWr(`REG_STATUS, 32'h1, `RESP_OKAY);
        rdChk(`REG_STATUS, 32'h1, 32'h0);
        axiWr(`REG_CTRL, 32'h7, `RESP_OKAY);
        repeat (2) @(posedge ref_clk);
        `CHK(powerEnableN, 1'h1)
        oscWatch(m);
        `CHK(m, 1'h0)
        pulseWake();
        rdChk(`REG_STATUS, 32'h3, 32'h2);
        axiWr(`REG_STATUS, 32'h2, `RESP_OKAY);
        rdChk(`REG_STATUS, 32'h3, 32'h0);
        axiWr(`REG_CTRL, 32'h8, `RESP_OKAY);
        `CHK({delayedRstOutOe, delayedRstOutN}, 2'h3)
        rdChk(`REG_STATUS, 32'hFF01FF00, 32'h0);
        rdChk(`REG_TX_POP, 32'h100, 32'h0);
        axiWr(8'h20, 32'h0, `RESP_DECERR);
        axiRd(8'h20);
        `CHK({r, d}, 34'h300000000)
        promSelectIn <= 1'h0;
        promClockIn <= 1'h0;
        resetN <= 1'h0;
        repeat (4) @(posedge ref_clk);
        `CHK({fifoDataOe, delayedRstOutOe, delayedRstOutN}, 3'h2)
        resetN <= 1'h1;
        @(posedge ref_clk);
        rdChk(`REG_PRODUCT, 32'hFFFF, {16'h0, `PID_ALT});
        rdChk(`REG_STATUS, 32'h1C, 32'hC);
        repeat (RST_DLY + 4) @(posedge ref_clk);
        `CHK({delayedRstOutOe, delayedRstOutN}, 2'h3)
        giveVerdict();
    end
endmodule
`default_nettype wire

// >>> usb_fifo_port.v
// Byte FIFO handshake port with AXI4-Lite access for the USB engine side
// Function
// R1: Eight-bit two-way data bus, bit 0 least significant, shared both ways.
// R2: While read strobe is low, drive the receive head byte on the bus.
// R3: Read strobe rising edge advances the receive store to the next byte.
// R4: Write strobe falling edge captures the bus byte into transmit store.
// R5: Transmit-space flag low only when a byte may be accepted.
// R6: Receive-available flag low whenever unread data is buffered; the code holds it high through each read strobe.
// R7: Send-now pulse while awake flags sending all transmit bytes at next IN.
// R8: Wake pulse while suspended with wakeup enabled raises a resume request.
// R9: Power-enable low once configured, high again during suspend.
// R10: Delayed reset output floats about 5 ms after start, then drives high.
// R11: External reset resets the block and drives delayed reset output low.
// R12: USB bus reset leaves the delayed reset output untouched.
// R13: Select strap low means 48 MHz mode, unpulled means 6 MHz mode.
// R14: Clock strap low reports the alternate product identifier.
// R15: Oscillator output stops toggling while suspended.
// R16: Factory test input must be held low in normal operation.
// R17: Receive store holds 128 bytes, drained by read strobes.
// R18: Transmit store holds 384 bytes, filled by write strobes.
// R19: Strobes pass two-stage synchronisers so each pulse acts once.
// R20: Data bus released whenever the read strobe is high.
`timescale 1ns/1ns
`default_nettype none
`include "usb_fifo_port_defs.vh"

module usb_fifo_port #(
    parameter integer RST_DELAY_CYCLES = `RST_DELAY_MS * 1000 * `CLK_MHZ
) (
    // Clock and reset
    input wire ref_clk,
    input wire reset_n,
    // FIFO handshake pins
    input wire [7:0] fifoDataIn,
    output reg [7:0] fifoDataOut,
    output reg fifoDataOe,
    input wire rdStrobeN,
    input wire wrStrobe,
    output reg txSpaceN,
    output reg rxAvailN,
    input wire sendNowWakeN,
    // Power, reset and clock pins
    output reg powerEnableN,
    output reg delayedRstOutN,
    output reg delayedRstOutOe,
    output reg oscOut,
    input wire testMode,
    // Strap sense on the configuration memory pins
    input wire promSelectIn,
    input wire promClockIn,
    // AXI4-Lite slave
    input wire [7:0] awaddr,
    input wire awvalid,
    output reg awready,
    input wire [31:0] wdata,
    input wire [3:0] wstrb,
    input wire wvalid,
    output reg wready,
    output reg [1:0] bresp,
    output reg bvalid,
    input wire bready,
    input wire [7:0] araddr,
    input wire arvalid,
    output reg arready,
    output reg [31:0] rdata,
    output reg [1:0] rresp,
    output reg rvalid,
    input wire rready
);

    // Stores
    reg [7:0] rxMem [0:127]; // [R17]
    reg [7:0] txMem [0:383]; // [R18]
    reg [6:0] rxRdPtr_q, rxWrPtr_q;
    reg [7:0] rxCount_q;
    reg [8:0] txRdPtr_q, txWrPtr_q, txCount_q;

    // Synchronisers, stage 1 feeds only stage 2
    reg rdS1_q, rdS2_q, rdS3_q;
    reg wrS1_q, wrS2_q, wrS3_q;
    reg snS1_q, snS2_q, snS3_q;
    reg [7:0] dataS1_q, dataS2_q, dataS3_q;

    // Control and state
    reg [2:0] ctrl_q;
    reg sendNow_q, resumeReq_q;
    reg strapDone_q, clk48Sel_q, altPid_q;
    reg [20:0] rstCnt_q;
    reg [4:0] oscCnt_q;
    reg [7:0] awAddr_q;
    reg [31:0] wData_q;
    reg [3:0] wStrb_q;

    wire configured = ctrl_q[`CTRL_CONFIGURED];
    wire suspended = ctrl_q[`CTRL_SUSPENDED];
    wire wakeEn = ctrl_q[`CTRL_WAKE_EN];

    // Strobe edges on synchronised copies
    wire rdRise = rdS2_q & ~rdS3_q; // [R19]
    wire wrFall = ~wrS2_q & wrS3_q; // [R19]
    wire snFall = ~snS2_q & snS3_q; // [R19]

    // Bus decode
    wire wrFire = ~awready & ~wready & ~bvalid;
    wire lane0 = wStrb_q[0];
    wire ctrlWr = wrFire & (awAddr_q == `REG_CTRL) & lane0;
    wire statusWr = wrFire & (awAddr_q == `REG_STATUS) & lane0;
    wire rxPushWr = wrFire & (awAddr_q == `REG_RX_PUSH) & lane0;
    wire busReset = ctrlWr & wData_q[`CTRL_BUS_RESET];
    wire arFire = arvalid & arready;
    wire wrMapped = (awAddr_q == `REG_CTRL) | (awAddr_q == `REG_STATUS) | (awAddr_q == `REG_RX_PUSH);
    wire rdMapped = (araddr == `REG_CTRL) | (araddr == `REG_STATUS) | (araddr == `REG_TX_POP)
        | (araddr == `REG_PRODUCT);

    // Store moves
    wire rxFull = (rxCount_q == `RX_DEPTH);
    wire rxEmpty = (rxCount_q == 8'h00);
    wire txFull = (txCount_q == `TX_DEPTH);
    wire txEmpty = (txCount_q == 9'h000);
    wire rxPush = rxPushWr & ~rxFull;
    wire rxPop = rdRise & ~rxEmpty; // [R3]
    wire txPush = wrFall & ~txFull; // [R4]
    wire txPop = arFire & (araddr == `REG_TX_POP) & ~txEmpty;

    reg [31:0] readMux;
    always @* begin
        readMux = 32'h0000_0000;
        case (araddr)
            `REG_CTRL: readMux = {29'h0000_0000, ctrl_q};
            `REG_STATUS: begin
                readMux[`ST_SEND_NOW] = sendNow_q;
                readMux[`ST_RESUME_REQ] = resumeReq_q;
                readMux[`ST_CLK48_SEL] = clk48Sel_q;
                readMux[`ST_ALT_PID] = altPid_q;
                readMux[`ST_TEST_MODE] = testMode;
                readMux[`ST_TX_COUNT_LSB +: 9] = txCount_q;
                readMux[`ST_RX_COUNT_LSB +: 8] = rxCount_q;
            end
            `REG_TX_POP: begin
                readMux[7:0] = txMem[txRdPtr_q];
                readMux[`TX_POP_VALID] = ~txEmpty;
            end
            `REG_PRODUCT: readMux[15:0] = altPid_q ? `PID_ALT : `PID_DEFAULT; // [R14]
            default: readMux = 32'h0000_0000;
        endcase
    end

    // Synchronisers and data pipeline
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            {rdS3_q, rdS2_q, rdS1_q} <= 3'h7;
            {wrS3_q, wrS2_q, wrS1_q} <= 3'h0;
            {snS3_q, snS2_q, snS1_q} <= 3'h7;
            {dataS3_q, dataS2_q, dataS1_q} <= 24'h00_0000;
        end else begin
            {rdS3_q, rdS2_q, rdS1_q} <= {rdS2_q, rdS1_q, rdStrobeN};
            {wrS3_q, wrS2_q, wrS1_q} <= {wrS2_q, wrS1_q, wrStrobe};
            {snS3_q, snS2_q, snS1_q} <= {snS2_q, snS1_q, sendNowWakeN};
            // Data aligned with the last high sample of the write strobe
            {dataS3_q, dataS2_q, dataS1_q} <= {dataS2_q, dataS1_q, fifoDataIn};
        end
    end

    // Store memories, no reset needed for contents
    always @(posedge ref_clk) begin
        if (rxPush)
            rxMem[rxWrPtr_q] <= wData_q[7:0];
        if (txPush)
            txMem[txWrPtr_q] <= dataS3_q; // [R4] [R1]
    end

    // Pointers and counts; bus reset flushes both stores
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            {rxRdPtr_q, rxWrPtr_q, rxCount_q} <= 22'h00_0000;
            {txRdPtr_q, txWrPtr_q, txCount_q} <= 27'h000_0000;
        end else if (busReset) begin
            {rxRdPtr_q, rxWrPtr_q, rxCount_q} <= 22'h00_0000;
            {txRdPtr_q, txWrPtr_q, txCount_q} <= 27'h000_0000;
        end else begin
            if (rxPush)
                rxWrPtr_q <= rxWrPtr_q + 7'h01;
            if (rxPop)
                rxRdPtr_q <= rxRdPtr_q + 7'h01; // [R3]
            if (rxPush & ~rxPop)
                rxCount_q <= rxCount_q + 8'h01;
            else if (rxPop & ~rxPush)
                rxCount_q <= rxCount_q - 8'h01;
            if (txPush)
                txWrPtr_q <= (txWrPtr_q == `TX_LAST) ? 9'h000 : txWrPtr_q + 9'h001;
            if (txPop)
                txRdPtr_q <= (txRdPtr_q == `TX_LAST) ? 9'h000 : txRdPtr_q + 9'h001;
            if (txPush & ~txPop)
                txCount_q <= txCount_q + 9'h001;
            else if (txPop & ~txPush)
                txCount_q <= txCount_q - 9'h001;
        end
    end

    // Handshake pins; flags stay inactive through a strobe cycle
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            fifoDataOut <= 8'h00;
            fifoDataOe <= 1'b0;
            txSpaceN <= 1'b1;
            rxAvailN <= 1'b1;
        end else begin
            fifoDataOut <= rxMem[rxRdPtr_q]; // [R2]
            fifoDataOe <= ~rdS2_q; // [R2] [R20]
            txSpaceN <= txFull | wrS2_q | wrS3_q | busReset; // [R5]
            rxAvailN <= rxEmpty | ~rdS2_q | ~rdS3_q | busReset; // [R6]
        end
    end

    // Control, sticky flags, straps; for the sticky flags the set wins over a clear
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_q <= `CTRL_RESET;
            sendNow_q <= 1'b0;
            resumeReq_q <= 1'b0;
            strapDone_q <= 1'b0;
            clk48Sel_q <= 1'b0;
            altPid_q <= 1'b0;
            powerEnableN <= 1'b1;
        end else begin
            if (ctrlWr)
                ctrl_q <= wData_q[2:0];
            if (busReset)
                ctrl_q[`CTRL_CONFIGURED] <= 1'b0;
            if (snFall & ~suspended)
                sendNow_q <= 1'b1; // [R7]
            else if (statusWr & wData_q[`ST_SEND_NOW])
                sendNow_q <= 1'b0;
            if (snFall & suspended & wakeEn)
                resumeReq_q <= 1'b1; // [R8]
            else if (statusWr & wData_q[`ST_RESUME_REQ])
                resumeReq_q <= 1'b0;
            // Straps caught once, on the first edge after release
            if (!strapDone_q) begin
                strapDone_q <= 1'b1;
                clk48Sel_q <= ~promSelectIn; // [R13]
                altPid_q <= ~promClockIn; // [R14]
            end
            powerEnableN <= ~(configured & ~suspended); // [R9]
        end
    end

    // Delayed reset output; only reset_n restarts it, never a bus reset
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rstCnt_q <= 21'h00_0000;
            delayedRstOutN <= 1'b0; // [R11]
            delayedRstOutOe <= 1'b1; // [R11]
        end else begin
            delayedRstOutN <= 1'b1;
            if (rstCnt_q < RST_DELAY_CYCLES[20:0]) begin
                rstCnt_q <= rstCnt_q + 21'h00_0001;
                delayedRstOutOe <= 1'b0; // [R10] [R12]
            end else begin
                delayedRstOutOe <= 1'b1; // [R10]
            end
        end
    end

    // Oscillator output, frozen while suspended
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            oscCnt_q <= 5'h00;
            oscOut <= 1'b0;
        end else if (!suspended) begin
            if (oscCnt_q == `OSC_HALF_CYCLES) begin
                oscCnt_q <= 5'h00;
                oscOut <= ~oscOut; // [R15]
            end else begin
                oscCnt_q <= oscCnt_q + 5'h01;
            end
        end
    end

    // AXI4-Lite write path
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            awready <= 1'b1;
            wready <= 1'b1;
            bvalid <= 1'b0;
            bresp <= `RESP_OKAY;
            awAddr_q <= 8'h00;
            wData_q <= 32'h0000_0000;
            wStrb_q <= 4'h0;
        end else begin
            if (awvalid & awready) begin
                awready <= 1'b0;
                awAddr_q <= {awaddr[7:2], 2'b00};
            end
            if (wvalid & wready) begin
                wready <= 1'b0;
                wData_q <= wdata;
                wStrb_q <= wstrb;
            end
            if (wrFire) begin
                bvalid <= 1'b1;
                bresp <= wrMapped ? `RESP_OKAY : `RESP_DECERR;
            end
            if (bvalid & bready) begin
                bvalid <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    // AXI4-Lite read path; reading the transmit port pops a byte
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= `RESP_OKAY;
        end else if (arFire) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= readMux;
            rresp <= rdMapped ? `RESP_OKAY : `RESP_DECERR;
        end else if (rvalid & rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
        end
    end

endmodule
`default_nettype wire

// >>> usb_fifo_port_defs.vh
// Constants for the USB byte FIFO parallel port
`ifndef USB_FIFO_PORT_DEFS_VH
`define USB_FIFO_PORT_DEFS_VH

// Register byte offsets
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_RX_PUSH 8'h08
`define REG_TX_POP 8'h0C
`define REG_PRODUCT 8'h10

// Control register fields
`define CTRL_CONFIGURED 0
`define CTRL_SUSPENDED 1
`define CTRL_WAKE_EN 2
`define CTRL_BUS_RESET 3

// Status and transmit pop register fields
`define ST_SEND_NOW 0
`define ST_RESUME_REQ 1
`define ST_CLK48_SEL 2
`define ST_ALT_PID 3
`define ST_TEST_MODE 4
`define ST_TX_COUNT_LSB 8
`define ST_RX_COUNT_LSB 24
`define TX_POP_VALID 8

// Store depths
`define RX_DEPTH 8'h80
`define TX_DEPTH 9'h180
`define TX_LAST 9'h17F

// Reset values
`define CTRL_RESET 3'h0

// Product identifiers, values arbitrary
`define PID_DEFAULT 16'h0A10
`define PID_ALT 16'h0A11

// Timing
`define CLK_MHZ 250
`define RST_DELAY_MS 5
`define OSC_HALF_CYCLES 5'h15

// AXI responses
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3

`endif

// >>> usb_fifo_port_sva.sv
// Assertions on the FIFO port pins
`timescale 1ns/1ns
`default_nettype none
module usb_fifo_port_sva #(
    parameter integer RST_DELAY_CYCLES = 20
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // FIFO pins
    input wire logic [7:0] fifoDataOut,
    input wire logic fifoDataOe,
    input wire logic rdStrobeN,
    input wire logic wrStrobe,
    input wire logic txSpaceN,
    input wire logic rxAvailN,
    // Reset output and read channel
    input wire logic delayedRstOutN,
    input wire logic delayedRstOutOe,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid
);
    // Margin covers the synchroniser slack either side
    localparam int DLO = RST_DELAY_CYCLES - 4;
    localparam int DHI = RST_DELAY_CYCLES + 4;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    sequence rdHeld;
        !rdStrobeN [*5];
    endsequence
    sequence rstRelease;
        !delayedRstOutOe ##[DLO:DHI] (delayedRstOutOe && delayedRstOutN);
    endsequence
    a_read_drives_bus: assert property (rdHeld |-> fifoDataOe)
        else $error("bus not driven in read");
    a_data_hold: assert property (fifoDataOe [*2] |-> $stable(fifoDataOut))
        else $error("read byte moved");
    a_bus_release: assert property (rdStrobeN [*5] |-> !fifoDataOe)
        else $error("bus driven while idle");
    a_rx_busy_read: assert property (fifoDataOe |-> rxAvailN)
        else $error("receive flag low in read");
    a_tx_busy_write: assert property (wrStrobe [*4] |-> txSpaceN)
        else $error("space flag low in write");
    a_rst_out_low: assert property ($rose(reset_n) |-> $past(delayedRstOutOe) && !$past(delayedRstOutN))
        else $error("reset output not low in reset");
    a_rst_out_delay: assert property ($rose(reset_n) |=> rstRelease)
        else $error("reset output delay wrong");
    a_read_answer: assert property (arvalid && arready |=> rvalid)
        else $error("read answer late");
endmodule
bind usb_fifo_port usb_fifo_port_sva #(.RST_DELAY_CYCLES(RST_DELAY_CYCLES)) u_usb_fifo_port_sva (
    .ref_clk(ref_clk), .reset_n(reset_n), .fifoDataOut(fifoDataOut), .fifoDataOe(fifoDataOe),
    .rdStrobeN(rdStrobeN), .wrStrobe(wrStrobe), .txSpaceN(txSpaceN), .rxAvailN(rxAvailN),
    .delayedRstOutN(delayedRstOutN), .delayedRstOutOe(delayedRstOutOe),
    .arvalid(arvalid), .arready(arready), .rvalid(rvalid)
);
`default_nettype wire
